// file: rtl/vpie_pkg.sv
`default_nettype none

package vpie_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_CH3_CTRL = 8'h00;
  localparam logic [7:0] OFF_CHAN0_CONTROL_REGISTER = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFF_IRQ_ARM = 8'h0C;
  localparam logic [7:0] OFF_IRQ_DISARM = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // ==========================================================
  // Field positions and widths
  localparam int CH3_RUN_POS = 0;
  localparam int CH3_GATE_POS = 1;
  localparam int IRQ_BITS = 5;
  localparam int FRAME_CHANNELS = 4;
  localparam int ERR_POS = 4;
  localparam int LINE_CH_POS = 1;
  localparam int FMT_LSB = 0;
  localparam int FMT_W = 2;

  // ==========================================================
  // Encodings and reset values
  localparam logic [1:0] FMT_RAW_LINE = 2'h3;
  localparam logic [1:0] FMT_RAW_FRAME = 2'h0;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [4:0] RESET_IRQ = 5'h00;

endpackage

`default_nettype wire

// file: rtl/vpie_edge_pulse.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Rising edge to one-cycle pulse
module vpie_edge_pulse #(
  parameter int WIDTH = 5
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] pulse_out
);

  logic [WIDTH-1:0] level_reg;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      level_reg <= '0;
    end
    else
    begin
      level_reg <= level_in;
    end
  end

  assign pulse_out = level_in & ~level_reg;

endmodule
`default_nettype wire

// file: rtl/vpie_arm_bits.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Arm bits: write-one set gated by enable, write-one clear not gated
module vpie_arm_bits #(
  parameter int WIDTH = 5
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic set_wr,
  input wire logic clr_wr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH-1:0] enable,
  output logic [WIDTH-1:0] arm_reg
);

  logic [WIDTH-1:0] set_mask;
  logic [WIDTH-1:0] clr_mask;
  logic [WIDTH-1:0] arm_next;

  always_comb
  begin
    set_mask = set_wr ? (wdata & enable) : '0;
    clr_mask = clr_wr ? wdata : '0;
    arm_next = (arm_reg | set_mask) & ~clr_mask;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      arm_reg <= '0;
    end
    else
    begin
      arm_reg <= arm_next;
    end
  end

endmodule
`default_nettype wire

// file: rtl/vpie_top.sv
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module vpie_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] frame_sync,
  input wire logic line_sync,
  input wire logic stream_error,
  output logic [3:0] frame_irq,
  output logic video_error_irq,
  output logic irq,
  output logic chan3_active,
  output logic chan3_video_clock_enable,
  output logic chan3_data_out_enable_n,
  output logic chan3_clock_out_enable_n
);

  // ==========================================================
  // Bus decode
  logic setup_ph;
  logic wr_acc;
  logic wr_ch3;
  logic wr_ch0;
  logic wr_en;
  logic wr_arm;
  logic wr_disarm;
  logic wr_status;
  logic wr_mask;
  logic mapped;
  logic [31:0] rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign wr_ch3 = wr_acc & hit(paddr, vpie_pkg::OFF_CH3_CTRL);
  assign wr_ch0 = wr_acc & hit(paddr, vpie_pkg::OFF_CHAN0_CONTROL_REGISTER);
  assign wr_en = wr_acc & hit(paddr, vpie_pkg::OFF_IRQ_ENABLE);
  assign wr_arm = wr_acc & hit(paddr, vpie_pkg::OFF_IRQ_ARM);
  assign wr_disarm = wr_acc & hit(paddr, vpie_pkg::OFF_IRQ_DISARM);
  assign wr_status = wr_acc & hit(paddr, vpie_pkg::OFF_IRQ_STATUS);
  assign wr_mask = wr_acc & hit(paddr, vpie_pkg::OFF_IRQ_MASK);
  assign pready = 1'b1;

  // ==========================================================
  // Channel 3 control
  logic chan3_run_bit_reg;
  logic chan3_clock_gate_reg;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan3_run_bit_reg <= 1'b0;
      chan3_clock_gate_reg <= 1'b0;
    end
    else if (wr_ch3)
    begin
      chan3_run_bit_reg <= pwdata[vpie_pkg::CH3_RUN_POS];
      chan3_clock_gate_reg <= pwdata[vpie_pkg::CH3_GATE_POS];
    end
  end

  assign chan3_active = chan3_run_bit_reg;
  assign chan3_video_clock_enable = chan3_clock_gate_reg;
  assign chan3_data_out_enable_n = ~chan3_clock_gate_reg;
  assign chan3_clock_out_enable_n = ~chan3_clock_gate_reg;

  // ==========================================================
  // Channel 0 format
  logic [vpie_pkg::FMT_W-1:0] chan0_capture_format_reg;
  logic line_mode;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan0_capture_format_reg <= vpie_pkg::FMT_RAW_FRAME;
    end
    else if (wr_ch0)
    begin
      chan0_capture_format_reg <=
        pwdata[vpie_pkg::FMT_LSB +: vpie_pkg::FMT_W];
    end
  end

  assign line_mode = (chan0_capture_format_reg == vpie_pkg::FMT_RAW_LINE);

  // ==========================================================
  // Interrupt enable and arm
  logic [vpie_pkg::IRQ_BITS-1:0] irq_enable_reg;
  logic [vpie_pkg::IRQ_BITS-1:0] irq_arm_reg;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_enable_reg <= vpie_pkg::RESET_IRQ;
    end
    else if (wr_en)
    begin
      irq_enable_reg <= pwdata[vpie_pkg::IRQ_BITS-1:0];
    end
  end

  vpie_arm_bits #(
    .WIDTH(vpie_pkg::IRQ_BITS)
  ) i_vpie_arm_bits (
    .mclk(mclk),
    .resetn(resetn),
    .set_wr(wr_arm),
    .clr_wr(wr_disarm),
    .wdata(pwdata[vpie_pkg::IRQ_BITS-1:0]),
    .enable(irq_enable_reg),
    .arm_reg(irq_arm_reg)
  );

  // ==========================================================
  // Events
  logic [4:0] sync_pulse;
  logic [vpie_pkg::IRQ_BITS-1:0] event_vec;
  logic [vpie_pkg::IRQ_BITS-1:0] gated;

  vpie_edge_pulse #(
    .WIDTH(5)
  ) i_vpie_edge_pulse (
    .mclk(mclk),
    .resetn(resetn),
    .level_in({line_sync, frame_sync}),
    .pulse_out(sync_pulse)
  );

  always_comb
  begin
    event_vec = {stream_error, sync_pulse[3:0]};
    if (line_mode)
    begin
      event_vec[vpie_pkg::LINE_CH_POS] = sync_pulse[4];
    end
  end

  assign gated = irq_enable_reg & irq_arm_reg & event_vec;

  // ==========================================================
  // Irq lines
  logic [vpie_pkg::IRQ_BITS-1:0] irq_line_reg;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_line_reg <= vpie_pkg::RESET_IRQ;
    end
    else
    begin
      irq_line_reg <= gated;
    end
  end

  assign frame_irq = irq_line_reg[vpie_pkg::FRAME_CHANNELS-1:0];
  assign video_error_irq = irq_line_reg[vpie_pkg::ERR_POS];

  // ==========================================================
  // Sticky status and mask
  logic [vpie_pkg::IRQ_BITS-1:0] irq_status_reg;
  logic [vpie_pkg::IRQ_BITS-1:0] irq_mask_reg;
  logic [vpie_pkg::IRQ_BITS-1:0] status_clr;
  logic irq_reg;

  assign status_clr = wr_status ? pwdata[vpie_pkg::IRQ_BITS-1:0] : '0;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_status_reg <= vpie_pkg::RESET_IRQ;
    end
    else
    begin
      irq_status_reg <= (irq_status_reg & ~status_clr) | gated;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_mask_reg <= vpie_pkg::RESET_IRQ;
    end
    else if (wr_mask)
    begin
      irq_mask_reg <= pwdata[vpie_pkg::IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |(((irq_status_reg & ~status_clr) | gated) & irq_mask_reg);
    end
  end

  assign irq = irq_reg;

  // ==========================================================
  // Read data
  always_comb
  begin
    rd_mux = vpie_pkg::RESET_WORD;
    mapped = 1'b1;
    case (paddr)
      vpie_pkg::OFF_CH3_CTRL:
      begin
        rd_mux[vpie_pkg::CH3_RUN_POS] = chan3_run_bit_reg;
        rd_mux[vpie_pkg::CH3_GATE_POS] = chan3_clock_gate_reg;
      end
      vpie_pkg::OFF_CHAN0_CONTROL_REGISTER:
      begin
        rd_mux[vpie_pkg::FMT_LSB +: vpie_pkg::FMT_W] =
          chan0_capture_format_reg;
      end
      vpie_pkg::OFF_IRQ_ENABLE:
      begin
        rd_mux[vpie_pkg::IRQ_BITS-1:0] = irq_enable_reg;
      end
      vpie_pkg::OFF_IRQ_ARM, vpie_pkg::OFF_IRQ_DISARM:
      begin
        rd_mux[vpie_pkg::IRQ_BITS-1:0] = irq_arm_reg;
      end
      vpie_pkg::OFF_IRQ_STATUS:
      begin
        rd_mux[vpie_pkg::IRQ_BITS-1:0] = irq_status_reg;
      end
      vpie_pkg::OFF_IRQ_MASK:
      begin
        rd_mux[vpie_pkg::IRQ_BITS-1:0] = irq_mask_reg;
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= vpie_pkg::RESET_WORD;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata <= pwrite ? vpie_pkg::RESET_WORD : rd_mux;
      pslverr <= ~mapped;
    end
  end

  // ==========================================================
  // Checks
  sequence ch3_write_s;
    psel && penable && pwrite && paddr == vpie_pkg::OFF_CH3_CTRL;
  endsequence

  sequence arm_write_s;
    psel && penable && pwrite && paddr == vpie_pkg::OFF_IRQ_ARM;
  endsequence

  gate_immediate_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    ch3_write_s |=> chan3_video_clock_enable == $past(pwdata[1]))
  else $error("Clock gate did not follow the write at once");

  out_enable_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    ch3_write_s |=> chan3_data_out_enable_n == !$past(pwdata[1])
      && chan3_clock_out_enable_n == chan3_data_out_enable_n)
  else $error("Channel 3 output enables do not track the gate bit");

  run_bit_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    ch3_write_s |=> chan3_active == $past(pwdata[0]))
  else $error("Channel 3 run state does not follow its bit");

  error_irq_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    stream_error && irq_enable_reg[4] && irq_arm_reg[4]
      |=> video_error_irq)
  else $error("Armed stream error gave no error irq");

  frame_once_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    frame_irq[0] |=> !frame_irq[0])
  else $error("Frame irq lasted more than one cycle");

  both_bits_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    frame_irq[2] |-> $past(irq_enable_reg[2]) && $past(irq_arm_reg[2]))
  else $error("Frame irq without enable and arm");

  line_mode_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    line_mode && sync_pulse[4] && irq_enable_reg[1] && irq_arm_reg[1]
      |=> frame_irq[1])
  else $error("Line event did not raise irq in raw line mode");

  enable_reserved_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    setup_ph && !pwrite && paddr == vpie_pkg::OFF_IRQ_ENABLE
      |=> prdata[31:5] == 27'h000_0000)
  else $error("Reserved enable bits read nonzero");

  arm_hold_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    irq_arm_reg[3] && !wr_disarm |=> irq_arm_reg[3])
  else $error("Arm bit dropped without a disarm write");

  arm_gated_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    arm_write_s ##0 (!irq_enable_reg[0] && !irq_arm_reg[0])
      |=> !irq_arm_reg[0])
  else $error("Arm bit set while its enable was clear");

  line_and_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !irq_enable_reg[3] |=> !frame_irq[3])
  else $error("Irq line high with its enable clear");

endmodule
`default_nettype wire

// file: sim/vpie_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Host: register bus master and irq input
module vpie_host_model (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  int n_hang = 0;
  logic err_seen = 1'b0;
  int n_irq_rise = 0;
  logic irq_q = 1'b0;

  // Counts rising edges of the irq line
  always @(posedge mclk)
  begin
    if (irq === 1'b1 && irq_q !== 1'b1)
      n_irq_rise++;
    irq_q <= irq;
  end

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      n_hang++;
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
endmodule

`default_nettype wire

// file: sim/tb_video_port_irq_enable_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module tb_video_port_irq_enable_ctrl;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] frame_sync = 4'h0;
  logic line_sync = 1'b0;
  logic stream_error = 1'b0;
  logic [3:0] frame_irq;
  logic video_error_irq, irq, act, clk_en, d_oe_n, c_oe_n;
  int n_mismatch = 0;
  int n_compared = 0;

  always #10 mclk = ~mclk;

  vpie_top i_vpie_top (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_sync(frame_sync), .line_sync(line_sync),
    .stream_error(stream_error), .frame_irq(frame_irq),
    .video_error_irq(video_error_irq), .irq(irq), .chan3_active(act),
    .chan3_video_clock_enable(clk_en), .chan3_data_out_enable_n(d_oe_n),
    .chan3_clock_out_enable_n(c_oe_n));

  vpie_host_model i_vpie_host_model (.mclk(mclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  // ==========================================================
  // Helpers
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    i_vpie_host_model.xfer(w, a, d, q);
    if (i_vpie_host_model.n_hang != 0)
    begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, q);
    chk(what, exp, q);
  endtask

  // Event levels for two edges; error and frame irq seen after each
  task automatic fire(input logic [3:0] fs, input logic ls,
                      input logic se, input logic [4:0] e1,
                      input logic [4:0] e2);
    frame_sync <= fs;
    line_sync <= ls;
    stream_error <= se;
    @(posedge mclk);
    #1;
    chk("irq first", {27'h0, e1}, {27'h0, video_error_irq, frame_irq});
    @(posedge mclk);
    frame_sync <= 4'h0;
    line_sync <= 1'b0;
    stream_error <= 1'b0;
    #1;
    chk("irq second", {27'h0, e2}, {27'h0, video_error_irq, frame_irq});
    @(posedge mclk);
  endtask

  function automatic logic [31:0] c3();
    return {28'h0, act, clk_en, d_oe_n, c_oe_n};
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    chk("ch3 reset", 32'h0000_0003, c3());
    rd("enable reset", vpie_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    wr(vpie_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    rd("enable ro", vpie_pkg::OFF_IRQ_ENABLE, 32'h0000_001F);
    wr(vpie_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
  endtask

  task automatic t_arm();
    wr(vpie_pkg::OFF_IRQ_ARM, 32'h0000_001F);
    rd("arm no enable", vpie_pkg::OFF_IRQ_ARM, 32'h0000_0000);
    wr(vpie_pkg::OFF_IRQ_ENABLE, 32'h0000_001F);
    wr(vpie_pkg::OFF_IRQ_ARM, 32'h0000_001F);
    wr(vpie_pkg::OFF_IRQ_ARM, 32'h0000_0000);
    rd("arm holds", vpie_pkg::OFF_IRQ_ARM, 32'h0000_001F);
    wr(vpie_pkg::OFF_IRQ_DISARM, 32'h0000_0004);
    rd("disarm", vpie_pkg::OFF_IRQ_DISARM, 32'h0000_001B);
  endtask

  task automatic t_frames();
    logic [4:0] e;
    for (int i = 0; i < 4; i++)
    begin
      e = (i == 2) ? 5'h00 : 5'h01 << i;
      fire(4'h1 << i, 1'b0, 1'b0, e, 5'h00);
    end
    wr(vpie_pkg::OFF_IRQ_ENABLE, 32'h0000_001E);
    fire(4'h1, 1'b0, 1'b0, 5'h00, 5'h00);
    fire(4'h0, 1'b0, 1'b1, 5'h10, 5'h10);
    wr(vpie_pkg::OFF_IRQ_ENABLE, 32'h0000_001F);
  endtask

  task automatic t_line();
    fire(4'h0, 1'b1, 1'b0, 5'h00, 5'h00);
    wr(vpie_pkg::OFF_CHAN0_CONTROL_REGISTER, 32'h0000_0003);
    rd("format", vpie_pkg::OFF_CHAN0_CONTROL_REGISTER, 32'h0000_0003);
    fire(4'h0, 1'b1, 1'b0, 5'h02, 5'h00);
    wr(vpie_pkg::OFF_CHAN0_CONTROL_REGISTER, 32'h0000_0000);
  endtask

  task automatic t_status();
    wr(vpie_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    rd("mask", vpie_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    wr(vpie_pkg::OFF_IRQ_STATUS, 32'h0000_001F);
    chk("irq idle", 32'h0000_0000, {31'h0, irq});
    fire(4'h8, 1'b0, 1'b0, 5'h08, 5'h00);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    fire(4'h1, 1'b0, 1'b0, 5'h01, 5'h00);
    chk("irq set", 32'h0000_0001, {31'h0, irq});
    rd("status", vpie_pkg::OFF_IRQ_STATUS, 32'h0000_0009);
    wr(vpie_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    chk("irq clr", 32'h0000_0000, {31'h0, irq});
    chk("irq rises", 32'h0000_0002, i_vpie_host_model.n_irq_rise);
    rd("unmapped", 8'h40, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, i_vpie_host_model.err_seen});
  endtask

  task automatic t_ch3();
    wr(vpie_pkg::OFF_CH3_CTRL, 32'h0000_0002);
    chk("gate on", 32'h0000_0004, c3());
    wr(vpie_pkg::OFF_CH3_CTRL, 32'h0000_0003);
    chk("run", 32'h0000_000C, c3());
    rd("ch3 ctrl", vpie_pkg::OFF_CH3_CTRL, 32'h0000_0003);
    wr(vpie_pkg::OFF_CH3_CTRL, 32'h0000_0002);
    chk("stop", 32'h0000_0004, c3());
    wr(vpie_pkg::OFF_CH3_CTRL, 32'h0000_0000);
    chk("gate off", 32'h0000_0003, c3());
  endtask

  task automatic t_reset();
    wr(vpie_pkg::OFF_CH3_CTRL, 32'h0000_0002);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd("enable after reset", vpie_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    rd("arm after reset", vpie_pkg::OFF_IRQ_ARM, 32'h0000_0000);
    chk("ch3 after reset", 32'h0000_0003, c3());
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_arm();
    t_frames();
    t_line();
    t_status();
    t_ch3();
    t_reset();
    summarize();
  end
endmodule

`default_nettype wire
